// >>> rtl/fsic_top.sv
// Added by the designer: the register addresses and the AXI4-Lite interface to the registers.
`include "fsic_params.svh"

module fsic_top (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst_n,
   // Issue from the processor.
   input wire logic issue_valid,
   input wire logic [2:0] issue_slot,
   input wire fsic_pkg::fsic_op_e issue_op,
   input wire logic [31:0] issue_src,
   input wire logic [31:0] issue_guard,
   input wire logic [6:0] issue_dest,
   // Flag updates from other floating-point units.
   input wire logic [5:0] other_flag_set,
   // Register-file write-back.
   output logic wb_valid,
   output logic [6:0] wb_dest,
   output logic [31:0] wb_data,
   // Status word exception flags and rounding mode.
   output logic [5:0] status_flags,
   output fsic_pkg::fsic_rmode_e status_rmode,
   // Interrupt.
   output logic irq,
   // AXI4-Lite slave.
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [7:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp
);
   import fsic_pkg::*;

   // Returns {flags, integer} for one single-precision source.
   function automatic logic [37:0] fsic_convert(input logic [31:0] x,
                                                input fsic_rmode_e rm);
      logic s;
      logic [7:0] e;
      logic [22:0] m;
      logic [23:0] mt;
      logic [55:0] fx;
      logic [31:0] ip;
      logic [32:0] mag;
      logic half;
      logic stk;
      logic up;
      logic inexact_flag;
      logic [5:0] fl;
      logic [31:0] r;
      s = x[31];
      e = x[30:23];
      m = x[22:0];
      mt = {1'b1, m};
      fx = '0;
      ip = '0;
      mag = '0;
      half = 1'b0;
      stk = 1'b0;
      up = 1'b0;
      inexact_flag = 1'b0;
      fl = '0;
      r = '0;
      if (e == `FSIC_EXP_SPECIAL) begin
         // NaN gives zero, infinity saturates; both are invalid.
         fl[`FSIC_BIT_INV] = 1'b1;
         if (m == 23'h0) begin
            r = s ? `FSIC_INT_MIN : `FSIC_INT_MAX;
         end
      end else if (e == 8'h00) begin
         // Denormals are flushed: the result stays zero.
         if (m != 23'h0) begin
            fl[`FSIC_BIT_IFZ] = 1'b1;
         end
      end else begin
         if (e >= `FSIC_EXP_INT) begin
            if (e > `FSIC_EXP_TOP) begin
               mag = 33'h1_0000_0000;
            end else begin
               mag = {9'h000, mt} << (e - `FSIC_EXP_INT);
            end
         end else if (e >= `FSIC_EXP_HALF) begin
            fx = {mt, 32'h0} >> (`FSIC_EXP_INT - e);
            ip = {8'h00, fx[55:32]};
            half = fx[31];
            stk = |fx[30:0];
         end else begin
            stk = 1'b1;
         end
         inexact_flag = half | stk;
         unique case (rm)
            FSIC_RM_NEAREST: up = half & (stk | ip[0]);
            FSIC_RM_ZERO: up = 1'b0;
            FSIC_RM_POS: up = inexact_flag & ~s;
            FSIC_RM_NEG: up = inexact_flag & s;
         endcase
         if (e < `FSIC_EXP_INT) begin
            mag = {1'b0, ip} + {32'h0, up};
         end
         if (mag > {1'b0, `FSIC_INT_MAX} + {32'h0, s}) begin
            fl[`FSIC_BIT_INV] = 1'b1;
            r = s ? `FSIC_INT_MIN : `FSIC_INT_MAX;
         end else begin
            fl[`FSIC_BIT_INX] = inexact_flag;
            r = s ? 32'h0 - mag[31:0] : mag[31:0];
         end
      end
      return {fl, r};
   endfunction

   // Issue stage.
   logic s1_valid;
   fsic_op_e s1_op;
   logic [31:0] s1_src;
   logic [6:0] s1_dest;
   fsic_rmode_e s1_rmode;
   // Compute stage.
   logic s2_valid;
   fsic_op_e s2_op;
   logic [6:0] s2_dest;
   logic [31:0] s2_int;
   logic [5:0] s2_flags;
   // Combinational conversion of the issue-stage operand.
   fsic_rmode_e eff_rmode;
   logic [37:0] conv_out;
   logic [5:0] conv_set;
   logic [5:0] next_flags;
   // Register bus.
   logic wr_fire;
   logic rd_fire;
   logic [31:0] wmask;
   logic [31:0] sw_rd;
   logic [31:0] sw_wr_val;
   logic sw_wr;
   logic clr_wr;
   logic en_wr;
   logic [1:0] irq_status;
   logic [1:0] irq_enable;
   logic [1:0] irq_event;
   logic [1:0] next_irq_status;

   assign eff_rmode = (s1_op == FSIC_OP_TRUNC) ? FSIC_RM_ZERO
                                               : s1_rmode;
   assign conv_out = fsic_convert(s1_src, eff_rmode);

   // Issue is taken only from the two allowed slots; a clear guard drops
   // the operation so neither result nor flags change.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_valid <= 1'b0;
         s1_op <= FSIC_OP_ROUND;
         s1_src <= '0;
         s1_dest <= '0;
         s1_rmode <= FSIC_RM_NEAREST;
      end else begin
         s1_valid <= issue_valid & issue_guard[0] &
                     (issue_slot == `FSIC_SLOT_A ||
                      issue_slot == `FSIC_SLOT_B);
         s1_op <= issue_op;
         s1_src <= issue_src;
         s1_dest <= issue_dest;
         s1_rmode <= status_rmode;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s2_valid <= 1'b0;
         s2_op <= FSIC_OP_ROUND;
         s2_dest <= '0;
         s2_int <= '0;
         s2_flags <= '0;
      end else begin
         s2_valid <= s1_valid;
         s2_op <= s1_op;
         s2_dest <= s1_dest;
         s2_int <= conv_out[31:0];
         s2_flags <= conv_out[37:32];
      end
   end

   // Third stage: the destination write.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_valid <= 1'b0;
         wb_dest <= '0;
         wb_data <= '0;
      end else begin
         wb_valid <= s2_valid;
         wb_dest <= s2_dest;
         if (s2_op == FSIC_OP_PROBE) begin
            wb_data <= {26'h0, s2_flags};
         end else begin
            wb_data <= s2_int;
         end
      end
   end

   // The probe never contributes; converting ops land with the write.
   assign conv_set = (s2_valid && s2_op != FSIC_OP_PROBE) ?
                     s2_flags : 6'h00;
   assign sw_wr_val = (sw_rd & ~wmask) | (s_axi_wdata & wmask);
   always_comb begin
      next_flags = status_flags;
      if (sw_wr) begin
         next_flags = sw_wr_val[5:0] & `FSIC_FLAG_MASK;
      end
      next_flags = next_flags | conv_set | other_flag_set;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_flags <= `FSIC_RST_FLAGS;
      end else begin
         status_flags <= next_flags;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         status_rmode <= FSIC_RM_NEAREST;
      end else if (sw_wr) begin
         status_rmode <= fsic_rmode_e'(
            sw_wr_val[`FSIC_RMODE_MSB:`FSIC_RMODE_LSB]);
      end
   end

   // Interrupt sources: a completed write-back and an invalid result.
   assign irq_event[`FSIC_IRQ_DONE] = s2_valid;
   assign irq_event[`FSIC_IRQ_INV] = s2_valid & s2_flags[`FSIC_BIT_INV];
   always_comb begin
      next_irq_status = irq_status;
      if (clr_wr) begin
         next_irq_status = irq_status & ~s_axi_wdata[1:0];
      end
      next_irq_status = next_irq_status | irq_event;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_status <= `FSIC_RST_IRQ;
         irq_enable <= `FSIC_RST_IRQ;
         irq <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         if (en_wr) begin
            irq_enable <= s_axi_wdata[1:0];
         end
         irq <= |(irq_status & irq_enable);
      end
   end

   // AXI4-Lite: address and data are taken together in one cycle.
   assign wr_fire = s_axi_awvalid & s_axi_awready &
                    s_axi_wvalid & s_axi_wready;
   assign rd_fire = s_axi_arvalid & s_axi_arready;
   assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                   {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
   assign sw_rd = {22'h0, status_rmode, 2'h0, status_flags};
   assign sw_wr = wr_fire && s_axi_awaddr == `FSIC_OFF_STATUS_WORD;
   assign clr_wr = wr_fire && s_axi_awaddr == `FSIC_OFF_IRQ_CLEAR &&
                   s_axi_wstrb[0];
   assign en_wr = wr_fire && s_axi_awaddr == `FSIC_OFF_IRQ_ENABLE &&
                  s_axi_wstrb[0];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
      end else begin
         s_axi_awready <= ~s_axi_awready & s_axi_awvalid & s_axi_wvalid &
                          ~s_axi_bvalid;
         s_axi_wready <= ~s_axi_wready & s_axi_awvalid & s_axi_wvalid &
                         ~s_axi_bvalid;
         if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            if (s_axi_awaddr == `FSIC_OFF_STATUS_WORD ||
                s_axi_awaddr == `FSIC_OFF_IRQ_CLEAR ||
                s_axi_awaddr == `FSIC_OFF_IRQ_ENABLE) begin
               s_axi_bresp <= 2'h0;
            end else begin
               s_axi_bresp <= 2'h2;
            end
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= 2'h0;
      end else begin
         s_axi_arready <= ~s_axi_arready & s_axi_arvalid & ~s_axi_rvalid;
         if (rd_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            unique case (s_axi_araddr)
               `FSIC_OFF_STATUS_WORD: s_axi_rdata <= sw_rd;
               `FSIC_OFF_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status};
               `FSIC_OFF_IRQ_CLEAR: s_axi_rdata <= '0;
               `FSIC_OFF_IRQ_ENABLE: s_axi_rdata <= {30'h0, irq_enable};
               default: begin
                  s_axi_rdata <= '0;
                  s_axi_rresp <= 2'h2;
               end
            endcase
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Checks.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_take_ok;
      issue_valid && issue_guard[0] && issue_slot == `FSIC_SLOT_A;
   endsequence

   sequence s_write_back;
      ##3 wb_valid;
   endsequence

   a_latency_three: assert property (
      s_take_ok |-> s_write_back ##0 wb_dest == $past(issue_dest, 3))
      else $error("write-back not exactly three cycles after issue");

   a_guard_blocks: assert property (
      (issue_valid && !issue_guard[0]) ##1 !issue_valid ##1 !issue_valid
      |-> ##1 !wb_valid)
      else $error("write-back happened with a clear guard");

   a_guard_flags: assert property (
      (issue_valid && !issue_guard[0]) ##2
      (other_flag_set == 6'h00 && !sw_wr)
      |=> status_flags == $past(status_flags))
      else $error("flags moved for a guarded-off operation");

   a_flags_sticky: assert property (
      !sw_wr |=> (status_flags & $past(status_flags)) ==
                 $past(status_flags))
      else $error("sticky flag fell without a status-word write");

   a_flags_or: assert property (
      other_flag_set != 6'h00 |=>
         (status_flags & $past(other_flag_set)) == $past(other_flag_set))
      else $error("simultaneous flag update was lost");

   a_probe_no_flags: assert property (
      (s2_valid && s2_op == FSIC_OP_PROBE && !sw_wr &&
       other_flag_set == 6'h00) |=> status_flags == $past(status_flags))
      else $error("probe operation changed the status flags");

   a_nan_flags_sync: assert property (
      (s_take_ok and (issue_op == FSIC_OP_ROUND &&
       issue_src[30:23] == 8'hff && issue_src[22:0] != 23'h0))
      |-> s_write_back ##0 (wb_data == 32'h0 &&
                            status_flags[`FSIC_BIT_INV]))
      else $error("NaN result or invalid flag wrong at write-back");

   a_inf_saturate: assert property (
      s_take_ok ##0 (issue_op == FSIC_OP_TRUNC &&
                     issue_src == 32'h7f800000)
      |-> ##3 wb_data == 32'h7fffffff)
      else $error("positive infinity did not saturate");

   a_probe_denorm: assert property (
      s_take_ok ##0 (issue_op == FSIC_OP_PROBE &&
                     issue_src[30:23] == 8'h00 && issue_src[22:0] != 23'h0)
      |-> ##3 wb_data == 32'h20)
      else $error("denormal probe did not report only the flush bit");

   a_trunc_half: assert property (
      s_take_ok ##0 (issue_op == FSIC_OP_TRUNC && !issue_src[31] &&
                     issue_src[30:23] == 8'd126)
      |-> ##3 wb_data == 32'h0)
      else $error("truncation rounded a fraction away from zero");

   a_nearest_up: assert property (
      s_take_ok ##0 (issue_op == FSIC_OP_ROUND && !issue_src[31] &&
                     status_rmode == FSIC_RM_NEAREST &&
                     issue_src[30:23] == 8'd126 && issue_src[22:0] != 23'h0)
      |-> ##3 wb_data == 32'h1)
      else $error("nearest rounding of a value above one half failed");

endmodule // fsic_top

// >>> rtl/fsic_params.svh
// Function
// - Mode-rounded convert writes signed integer result.
// - Mode-rounded ops round by status-word mode.
// - Truncating convert always rounds toward zero.
// - Denormal input becomes zero, sets flushed flag.
// - Conversion exceptions set matching status flags.
// - Flags sticky; only status-word write clears.
// - Flags update with destination write.
// - Simultaneous flag updates OR together.
// - Guard LSB enables destination write.
// - Zero guard leaves flags untouched.
// - Flag-probe writes would-be flags as integer.
// - Probe vector matches status-word flag positions.
// - Flag-probe never modifies status-word flags.
// - Probe of denormal sets flushed bit.
`ifndef FSIC_PARAMS_SVH
`define FSIC_PARAMS_SVH

`define FSIC_ADDR_W 8
`define FSIC_OFF_STATUS_WORD 8'h00
`define FSIC_OFF_IRQ_STATUS 8'h04
`define FSIC_OFF_IRQ_CLEAR 8'h08
`define FSIC_OFF_IRQ_ENABLE 8'h0c

`define FSIC_FLAG_W 6
`define FSIC_BIT_INX 1
`define FSIC_BIT_INV 4
`define FSIC_BIT_IFZ 5
`define FSIC_FLAG_MASK 6'h32
`define FSIC_RMODE_LSB 8
`define FSIC_RMODE_MSB 9

`define FSIC_IRQ_W 2
`define FSIC_IRQ_DONE 0
`define FSIC_IRQ_INV 1

`define FSIC_RST_FLAGS 6'h00
`define FSIC_RST_IRQ 2'h0

`define FSIC_SLOT_A 3'h1
`define FSIC_SLOT_B 3'h4
`define FSIC_LATENCY 3

`define FSIC_EXP_SPECIAL 8'hff
`define FSIC_EXP_INT 8'd150
`define FSIC_EXP_HALF 8'd126
`define FSIC_EXP_TOP 8'd158
`define FSIC_INT_MAX 32'h7fffffff
`define FSIC_INT_MIN 32'h80000000

`endif

// >>> rtl/fsic_pkg.sv
package fsic_pkg;
   typedef enum logic [2:0] {
      FSIC_OP_ROUND = 3'b001,
      FSIC_OP_TRUNC = 3'b010,
      FSIC_OP_PROBE = 3'b100
   } fsic_op_e;

   typedef enum logic [1:0] {
      FSIC_RM_NEAREST = 2'h0,
      FSIC_RM_ZERO = 2'h1,
      FSIC_RM_POS = 2'h2,
      FSIC_RM_NEG = 2'h3
   } fsic_rmode_e;
endpackage

// >>> verif/fsic_regfile.sv
module fsic_regfile (
   // Clock.
   input wire logic clk,
   // Write-back from the converter.
   input wire logic wb_valid,
   input wire logic [6:0] wb_dest,
   input wire logic [31:0] wb_data
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [31:0] regs [128];

   // Every entry starts with a marker so an unwanted write shows up.
   initial begin
      foreach (regs[i]) begin
         regs[i] = 32'h0badf00d;
      end
   end

   // An entry changes only on a write-back pulse.
   always @(posedge clk) begin
      if (wb_valid === 1'b1) begin
         regs[wb_dest] <= wb_data;
      end
   end
endmodule // fsic_regfile

// >>> verif/fsic_top_tb.sv
module fsic_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import fsic_pkg::*;

   typedef struct {
      fsic_op_e op;
      logic [1:0] rm;
      logic [31:0] src;
      logic [31:0] d;
      logic [5:0] f;
   } fsic_row_s;

   localparam fsic_op_e opr = FSIC_OP_ROUND;
   localparam fsic_op_e opt = FSIC_OP_TRUNC;
   localparam fsic_op_e opp = FSIC_OP_PROBE;

   logic clk, rst_n, issue_valid, wb_valid, irq;
   logic [2:0] issue_slot;
   fsic_op_e issue_op;
   logic [31:0] issue_src, issue_guard, wb_data, rd;
   logic [6:0] issue_dest, wb_dest;
   logic [5:0] other_flag_set, status_flags;
   fsic_rmode_e status_rmode;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   int n_fail = 0;
   int comparisons = 0;
   fsic_row_s rows [26];

   fsic_top i_fsic_top (
      .clk(clk), .rst_n(rst_n), .issue_valid(issue_valid),
      .issue_slot(issue_slot), .issue_op(issue_op), .issue_src(issue_src),
      .issue_guard(issue_guard), .issue_dest(issue_dest),
      .other_flag_set(other_flag_set), .wb_valid(wb_valid),
      .wb_dest(wb_dest), .wb_data(wb_data), .status_flags(status_flags),
      .status_rmode(status_rmode), .irq(irq),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
      .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
      .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp)
   );

   fsic_regfile i_fsic_regfile (
      .clk(clk), .wb_valid(wb_valid), .wb_dest(wb_dest), .wb_data(wb_data)
   );

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      logic aw_ok, w_ok;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      @(posedge clk);
      s_axi_awvalid <= 1'b1;
      s_axi_awaddr <= a;
      s_axi_wvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         if (s_axi_awvalid && s_axi_awready === 1'b1) begin
            aw_ok = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready === 1'b1) begin
            w_ok = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge clk); while (s_axi_bvalid !== 1'b1);
      rr = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      s_axi_arvalid <= 1'b1;
      s_axi_araddr <= a;
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge clk);
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // Returns just after the edge at which the result is due.
   task automatic iss(input fsic_op_e op, input logic [31:0] src, g,
                      input logic [2:0] sl, input logic [5:0] oth);
      @(posedge clk);
      issue_valid <= 1'b1;
      issue_op <= op;
      issue_src <= src;
      issue_guard <= g;
      issue_slot <= sl;
      @(posedge clk);
      issue_valid <= 1'b0;
      @(posedge clk);
      other_flag_set <= oth;
      @(posedge clk);
      other_flag_set <= 6'h00;
      #1;
   endtask

   task automatic tdone(input string nm);
      $display("test %s done", nm);
   endtask

   initial begin
      #200000;
      n_fail++;
      summarize();
   end

   initial begin
      rows = '{
         '{opr, 2'h0, 32'h40400000, 32'h3, 6'h00},
         '{opr, 2'h0, 32'h40247ae1, 32'h3, 6'h02},
         '{opr, 2'h0, 32'hff4fffff, 32'h80000000, 6'h10},
         '{opr, 2'h0, 32'h7f800000, 32'h7fffffff, 6'h10},
         '{opr, 2'h0, 32'hbfc147ae, 32'hfffffffe, 6'h02},
         '{opr, 2'h0, 32'h00400000, 32'h0, 6'h20},
         '{opr, 2'h0, 32'hffffffff, 32'h0, 6'h10},
         '{opr, 2'h0, 32'hffbfffff, 32'h0, 6'h10},
         '{opr, 2'h0, 32'h40200000, 32'h2, 6'h02},
         '{opr, 2'h0, 32'h40600000, 32'h4, 6'h02},
         '{opr, 2'h0, 32'hcf000000, 32'h80000000, 6'h00},
         '{opr, 2'h0, 32'h4f000000, 32'h7fffffff, 6'h10},
         '{opr, 2'h1, 32'h40247ae1, 32'h2, 6'h02},
         '{opr, 2'h2, 32'hbfc147ae, 32'hffffffff, 6'h02},
         '{opr, 2'h2, 32'h40247ae1, 32'h3, 6'h02},
         '{opr, 2'h3, 32'h40247ae1, 32'h2, 6'h02},
         '{opt, 2'h2, 32'h40247ae1, 32'h2, 6'h02},
         '{opt, 2'h3, 32'hbfc147ae, 32'hffffffff, 6'h02},
         '{opt, 2'h0, 32'h7f800000, 32'h7fffffff, 6'h10},
         '{opt, 2'h0, 32'hff4fffff, 32'h80000000, 6'h10},
         '{opt, 2'h2, 32'h3f400000, 32'h0, 6'h02},
         '{opp, 2'h1, 32'h40247ae1, 32'h2, 6'h00},
         '{opr, 2'h0, 32'h3f400000, 32'h1, 6'h02},
         '{opp, 2'h0, 32'h7f800000, 32'h10, 6'h00},
         '{opp, 2'h0, 32'h00400000, 32'h20, 6'h00},
         '{opp, 2'h0, 32'h40400000, 32'h0, 6'h00}};
      {issue_valid, issue_slot, issue_src, issue_guard} = '0;
      {issue_dest, other_flag_set, s_axi_awvalid, s_axi_awaddr} = '0;
      {s_axi_wvalid, s_axi_wdata, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_araddr, s_axi_rready} = '0;
      issue_op = opr;
      s_axi_wstrb = 4'hf;
      rst_n = 1'b0;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      #1;
      chk("flags", 32'h0, {26'h0, status_flags});
      chk("irq", 32'h0, {31'h0, irq});
      for (int i = 0; i < 4; i++) begin
         axr(8'(i * 4));
         chk("reset reg", 32'h0, rd);
      end
      tdone("reset");
      foreach (rows[i]) begin
         axw(8'h00, {22'h0, rows[i].rm, 8'h00});
         chk("rmode", {30'h0, rows[i].rm}, {30'h0, status_rmode});
         issue_dest <= 7'(i + 16);
         iss(rows[i].op, rows[i].src, 32'h1, i[0] ? 3'h4 : 3'h1, 6'h00);
         chk("wb_valid", 32'h1, {31'h0, wb_valid});
         chk("wb_data", rows[i].d, wb_data);
         chk("flags", {26'h0, rows[i].f}, {26'h0, status_flags});
         @(posedge clk);
         #1;
         chk("dest reg", rows[i].d, i_fsic_regfile.regs[i + 16]);
      end
      tdone("table");
      axw(8'h00, 32'h0);
      issue_dest <= 7'h64;
      iss(opr, 32'h7f800000, 32'hfffffffe, 3'h1, 6'h00);
      chk("wb_valid", 32'h0, {31'h0, wb_valid});
      chk("flags", 32'h0, {26'h0, status_flags});
      iss(opr, 32'h7f800000, 32'h1, 3'h2, 6'h00);
      chk("wb_valid", 32'h0, {31'h0, wb_valid});
      @(posedge clk);
      #1;
      chk("dest reg", 32'h0badf00d, i_fsic_regfile.regs[100]);
      tdone("guard and slot");
      iss(opr, 32'h40247ae1, 32'h1, 3'h4, 6'h10);
      chk("flags", 32'h12, {26'h0, status_flags});
      iss(opr, 32'h40400000, 32'h1, 3'h1, 6'h00);
      chk("flags", 32'h12, {26'h0, status_flags});
      iss(opp, 32'h00400000, 32'h1, 3'h4, 6'h00);
      chk("flags", 32'h12, {26'h0, status_flags});
      axw(8'h00, 32'h0000003f);
      axr(8'h00);
      chk("status word", 32'h32, rd);
      axw(8'h00, 32'h0);
      chk("flags", 32'h0, {26'h0, status_flags});
      tdone("sticky");
      @(posedge clk);
      issue_valid <= 1'b1;
      issue_op <= opr;
      issue_src <= 32'h40400000;
      issue_guard <= 32'h1;
      issue_slot <= 3'h1;
      @(posedge clk);
      issue_op <= opt;
      issue_src <= 32'hbfc147ae;
      issue_slot <= 3'h4;
      @(posedge clk);
      issue_valid <= 1'b0;
      @(posedge clk);
      #1;
      chk("first", 32'h3, wb_data);
      @(posedge clk);
      #1;
      chk("second", 32'hffffffff, wb_data);
      tdone("back to back");
      axw(8'h08, 32'h3);
      axw(8'h0c, 32'hffffffff);
      axr(8'h0c);
      chk("irq enable", 32'h3, rd);
      axw(8'h0c, 32'h2);
      iss(opr, 32'h40400000, 32'h1, 3'h1, 6'h00);
      @(posedge clk);
      #1;
      chk("irq", 32'h0, {31'h0, irq});
      iss(opr, 32'h7f800000, 32'h1, 3'h4, 6'h00);
      @(posedge clk);
      #1;
      chk("irq", 32'h1, {31'h0, irq});
      axr(8'h04);
      chk("irq status", 32'h3, rd);
      axw(8'h08, 32'h3);
      axr(8'h08);
      chk("irq clear", 32'h0, rd);
      axr(8'h04);
      chk("irq status", 32'h0, rd);
      chk("irq", 32'h0, {31'h0, irq});
      tdone("interrupt");
      axw(8'h10, 32'h1);
      chk("bresp", 32'h2, {30'h0, rr});
      axr(8'h10);
      chk("rresp", 32'h2, {30'h0, rr});
      chk("rdata", 32'h0, rd);
      tdone("unmapped");
      summarize();
   end
endmodule // fsic_top_tb
